// >>> rtl/hif_pkg.sv
package hif_pkg;

    // fifo geometry and marks
    localparam logic [6:0] FIFO_DEPTH = 7'h60;
    localparam logic [6:0] FIFO_LAST = 7'h5f;
    localparam logic [6:0] FIFO_LOW_MARK = 7'h04;

    // water levels, two choices per direction (selected in io_cfg1)
    localparam logic [6:0] WL_RX_LO = 7'h40;
    localparam logic [6:0] WL_RX_HI = 7'h50;
    localparam logic [6:0] WL_TX_LO = 7'h20;
    localparam logic [6:0] WL_TX_HI = 7'h10;

    // register addresses (6-bit serial address space)
    localparam logic [5:0] ADDR_IO_CFG1 = 6'h01;
    localparam logic [5:0] ADDR_MASK_MAIN = 6'h14;
    localparam logic [5:0] ADDR_MASK_TIM = 6'h15;
    localparam logic [5:0] ADDR_MASK_ERR = 6'h16;
    localparam logic [5:0] ADDR_IRQ_MAIN = 6'h17;
    localparam logic [5:0] ADDR_IRQ_TIM = 6'h18;
    localparam logic [5:0] ADDR_IRQ_ERR = 6'h19;
    localparam logic [5:0] ADDR_FIFO_ST1 = 6'h1a;
    localparam logic [5:0] ADDR_FIFO_ST2 = 6'h1b;

    // field positions
    localparam int CFG_WL_RX_BIT = 0;
    localparam int CFG_WL_TX_BIT = 1;
    localparam int MAIN_SRC_LSB = 2;
    localparam int MAIN_WL_IDX = 4;

    // reset values
    localparam logic [7:0] CFG_RST = 8'h00;
    localparam logic [7:0] MASK_RST = 8'h00;

    // first-byte mode field and fifo / command codes
    localparam logic [1:0] MODE_WRITE = 2'h0;
    localparam logic [1:0] MODE_READ = 2'h1;
    localparam logic [1:0] MODE_FIFO = 2'h2;
    localparam logic [5:0] FIFO_LOAD_CODE = 6'h00;
    localparam logic [5:0] FIFO_READ_CODE = 6'h3f;
    localparam logic [5:0] CMD_CLEAR_A = 6'h02;
    localparam logic [5:0] CMD_CLEAR_B = 6'h03;

    typedef enum logic [2:0] {
        ST_IDLE, ST_WR, ST_RD, ST_FLOAD, ST_FREAD, ST_IGNORE
    } hif_state_type;

    // status of the last received byte
    typedef struct packed {
        logic incomplete;
        logic [2:0] last_byte_valid_bits;
        logic last_byte_parity_flag;
    } hif_lb_type;

    // second fifo status register contents
    typedef struct packed {
        logic ovf;
        logic unf;
        hif_lb_type lb;
    } hif_fifo_st_type;

endpackage : hif_pkg

// >>> rtl/hif_top.sv
`timescale 1ns/100ps

// What this block does
// R01: immediate command may chain into another access
// R02: three interrupt registers, main has pointers
// R03: event sets source bit and raises irq
// R04: host reads interrupt registers in one burst
// R05: reading interrupt register clears it, except pointers
// R06: pointer clears only when its register read
// R07: irq drops after last pending bit read
// R08: mask gates irq, source bit still set
// R09: shared 96 byte fifo for tx and rx
// R10: tx water event on count wl+1 to wl
// R11: rx water event on count wl-1 to wl
// R12: tx short load: event when count below four
// R13: no fifo events during fifo serial mode
// R14: host ends select early, fast serial clock
// R15: two water levels each for rx, tx
// R16: reception start empties fifo, clears status
// R17: status one shows live unread byte count
// R18: status two last-byte bits clear on read
// R19: overflow flag on write into full fifo
// R20: underflow flag on read from empty fifo
// R21: mode 10 with zeros loads, ones reads
// R22: host waits during long commands
// R23: irq is or of unmasked pending bits
module hif_top
    import hif_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic sclk,
    input wire logic ss_n,
    input wire logic mosi,
    output logic miso_o,
    output logic miso_oe,
    output logic irq,
    input wire logic [5:0] main_evt,
    input wire logic [7:0] tim_evt,
    input wire logic [7:0] err_evt,
    input wire logic rx_active,
    input wire logic tx_active,
    input wire logic tx_all_loaded,
    input wire logic rx_start,
    input wire logic fr_push,
    input wire logic [7:0] fr_wdata,
    input wire logic fr_pop,
    output logic [7:0] fr_rdata,
    output logic fr_empty,
    input wire logic lb_stb,
    input wire hif_lb_type lb_info,
    output logic cmd_stb,
    output logic [5:0] cmd_code
);
    // link domain, clocked by sclk
    logic link_rst_n, byte_tgl_r, rd_mode_r;
    logic [2:0] bit_cnt_r;
    logic [6:0] rx_sh_r;
    logic [7:0] byte_r, tx_sh_r, rd_data_r;
    // select high holds the serial port in reset
    assign link_rst_n = rst_n & ~ss_n;
    // mosi is taken on the falling edge
    always_ff @(negedge sclk or negedge link_rst_n) begin
        if (!link_rst_n) begin
            bit_cnt_r <= 3'h0;
            rx_sh_r <= 7'h00;
        end else begin
            bit_cnt_r <= bit_cnt_r + 3'h1;
            rx_sh_r <= {rx_sh_r[5:0], mosi};
        end
    end
    // a whole byte is handed over with a toggle; a cut byte never toggles
    always_ff @(negedge sclk or negedge rst_n) begin
        if (!rst_n) begin
            byte_r <= 8'h00;
            byte_tgl_r <= 1'b0;
        end else if (bit_cnt_r == 3'h7) begin
            byte_r <= {rx_sh_r, mosi};
            byte_tgl_r <= ~byte_tgl_r;
        end
    end
    // read data is launched on rising edges; rd_data_r is held still by mclk
    // from before the first rising edge of a byte, so it is sampled quasi-static
    always_ff @(posedge sclk or negedge link_rst_n) begin
        if (!link_rst_n) begin
            tx_sh_r <= 8'h00;
        end else if (bit_cnt_r == 3'h0) begin
            tx_sh_r <= rd_data_r;
        end else begin
            tx_sh_r <= {tx_sh_r[6:0], 1'b0};
        end
    end
    assign miso_o = tx_sh_r[7];
    assign miso_oe = ~ss_n & rd_mode_r;
    // core domain, clocked by mclk
    logic ss_m1_r, ss_m2_r;
    logic tg_m1_r, tg_m2_r, tg_m3_r;
    logic ev;
    hif_state_type state_r;
    logic [5:0] addr_r;
    logic [5:0] addr_sel;
    logic [7:0] reg_mux;
    logic [7:0] cfg_r;
    logic [7:0] mask_r [3];
    logic [5:0] main_src_r;
    logic [5:0] src_set;
    logic [7:0] aux_r [2];
    logic [7:0] aux_evt [2];
    logic [7:0] mem_r [96];
    logic [6:0] wr_ptr_r, rd_ptr_r, count_r, count_nxt, tx_loaded_r;
    hif_fifo_st_type st2_r;
    logic wr_en, rd_clr, host_push, host_pop, push, pop, do_push, do_pop;
    logic flush, clear_cmd, fifo_mode, ovf_set, unf_set;
    logic [6:0] wl_rx, wl_tx;
    logic wl_tx_hit, wl_rx_hit, wl_evt;
    // select and byte toggle synchronisers
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ss_m1_r <= 1'b1;
            ss_m2_r <= 1'b1;
            tg_m1_r <= 1'b0;
            tg_m2_r <= 1'b0;
            tg_m3_r <= 1'b0;
        end else begin
            ss_m1_r <= ss_n;
            ss_m2_r <= ss_m1_r;
            tg_m1_r <= byte_tgl_r;
            tg_m2_r <= tg_m1_r;
            tg_m3_r <= tg_m2_r;
        end
    end
    assign ev = tg_m2_r ^ tg_m3_r;
    // per-byte strobes of the serial port
    assign wr_en = ev & (state_r == ST_WR);
    assign rd_clr = ev & (state_r == ST_RD);
    assign host_push = ev & (state_r == ST_FLOAD);
    assign host_pop = ev & (state_r == ST_FREAD);
    assign clear_cmd = ev & (state_r == ST_IDLE) & (&byte_r[7:6])
        & ((byte_r[5:0] == CMD_CLEAR_A) | (byte_r[5:0] == CMD_CLEAR_B));
    assign fifo_mode = (state_r == ST_FLOAD) | (state_r == ST_FREAD); // R13
    // address of the next byte to present on miso
    assign addr_sel = (state_r == ST_IDLE) ? byte_r[5:0] : addr_r + 6'h01;
    // register read view; unmapped addresses read as zero
    always_comb begin
        case (addr_sel)
            ADDR_IO_CFG1: reg_mux = cfg_r;
            ADDR_MASK_MAIN: reg_mux = mask_r[0];
            ADDR_MASK_TIM: reg_mux = mask_r[1];
            ADDR_MASK_ERR: reg_mux = mask_r[2];
            ADDR_IRQ_MAIN: reg_mux = {main_src_r, |aux_r[0], |aux_r[1]}; // R02 R06
            ADDR_IRQ_TIM: reg_mux = aux_r[0];
            ADDR_IRQ_ERR: reg_mux = aux_r[1];
            ADDR_FIFO_ST1: reg_mux = {1'b0, count_r}; // R17
            ADDR_FIFO_ST2: reg_mux = {1'b0, st2_r};
            default: reg_mux = 8'h00;
        endcase
    end
    // serial command decoder; select high returns it to the first byte
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= ST_IDLE;
            addr_r <= 6'h00;
            rd_mode_r <= 1'b0;
            rd_data_r <= 8'h00;
            cmd_stb <= 1'b0;
            cmd_code <= 6'h00;
        end else begin
            cmd_stb <= 1'b0;
            if (ss_m2_r) begin
                state_r <= ST_IDLE;
                rd_mode_r <= 1'b0;
            end else if (ev) begin
                case (state_r)
                    ST_IDLE: begin
                        addr_r <= byte_r[5:0];
                        case (byte_r[7:6])
                            MODE_WRITE: state_r <= ST_WR;
                            MODE_READ: begin
                                state_r <= ST_RD;
                                rd_mode_r <= 1'b1;
                                rd_data_r <= reg_mux;
                            end
                            MODE_FIFO: begin
                                if (byte_r[5:0] == FIFO_LOAD_CODE) begin // R21
                                    state_r <= ST_FLOAD;
                                end else if (byte_r[5:0] == FIFO_READ_CODE) begin // R21
                                    state_r <= ST_FREAD;
                                    rd_mode_r <= 1'b1;
                                    rd_data_r <= fr_empty ? 8'h00 : mem_r[rd_ptr_r];
                                end else begin
                                    state_r <= ST_IGNORE;
                                end
                            end
                            default: begin
                                // immediate command: next byte is a fresh mode byte
                                cmd_stb <= 1'b1; // R01
                                cmd_code <= byte_r[5:0];
                            end
                        endcase
                    end
                    ST_WR: addr_r <= addr_r + 6'h01;
                    ST_RD: begin
                        addr_r <= addr_r + 6'h01; // R04
                        rd_data_r <= reg_mux;
                    end
                    ST_FREAD: begin
                        // the byte just read leaves; next one is presented
                        if (count_r > 7'h01) begin
                            rd_data_r <= mem_r[ptr_inc(rd_ptr_r)];
                        end else begin
                            rd_data_r <= 8'h00;
                        end
                    end
                    default: ;
                endcase
            end
        end
    end
    // software writable configuration and masks
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cfg_r <= CFG_RST;
            mask_r[0] <= MASK_RST;
            mask_r[1] <= MASK_RST;
            mask_r[2] <= MASK_RST;
        end else if (wr_en) begin
            case (addr_r)
                ADDR_IO_CFG1: cfg_r <= byte_r;
                ADDR_MASK_MAIN: mask_r[0] <= byte_r;
                ADDR_MASK_TIM: mask_r[1] <= byte_r;
                ADDR_MASK_ERR: mask_r[2] <= byte_r;
                default: ;
            endcase
        end
    end
    // fifo storage, pointers and flags
    function automatic logic [6:0] ptr_inc(input logic [6:0] p);
        ptr_inc = (p == FIFO_LAST) ? 7'h00 : p + 7'h01;
    endfunction : ptr_inc
    assign push = host_push | fr_push;
    assign pop = host_pop | fr_pop;
    assign flush = rx_start | clear_cmd; // R16
    assign do_push = push & (count_r != FIFO_DEPTH);
    assign do_pop = pop & (count_r != 7'h00);
    assign ovf_set = push & (count_r == FIFO_DEPTH); // R19
    assign unf_set = pop & (count_r == 7'h00); // R20
    assign fr_empty = (count_r == 7'h00);
    assign fr_rdata = mem_r[rd_ptr_r];
    always_comb begin
        if (flush) begin
            count_nxt = 7'h00;
        end else begin
            count_nxt = count_r + {6'h00, do_push} - {6'h00, do_pop};
        end
    end
    // storage; the host load wins the write port over the receiver
    always_ff @(posedge mclk) begin
        if (do_push & ~flush) begin
            mem_r[wr_ptr_r] <= host_push ? byte_r : fr_wdata; // R09
        end
    end
    // pointers, live count and bytes loaded for the current frame
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr_r <= 7'h00;
            rd_ptr_r <= 7'h00;
            count_r <= 7'h00;
            tx_loaded_r <= 7'h00;
        end else begin
            count_r <= count_nxt; // R17
            if (flush) begin
                wr_ptr_r <= 7'h00;
                rd_ptr_r <= 7'h00;
                tx_loaded_r <= 7'h00;
            end else begin
                if (do_push) begin
                    wr_ptr_r <= ptr_inc(wr_ptr_r);
                end
                if (do_pop) begin
                    rd_ptr_r <= ptr_inc(rd_ptr_r);
                end
                if (host_push & (tx_loaded_r != 7'h7f)) begin
                    tx_loaded_r <= tx_loaded_r + 7'h01;
                end
            end
        end
    end
    // second status register: error flags set-win, all bits clear on read
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            st2_r <= '0;
        end else if (rx_start) begin
            st2_r <= '0; // R16
        end else begin
            if (lb_stb) begin
                st2_r.lb <= lb_info;
            end else if (rd_clr & (addr_r == ADDR_FIFO_ST2)) begin
                st2_r.lb <= st2_r.lb & ~rd_data_r[4:0]; // R18
            end
            if (rd_clr & (addr_r == ADDR_FIFO_ST2)) begin
                st2_r.ovf <= (st2_r.ovf & ~rd_data_r[6]) | ovf_set;
                st2_r.unf <= (st2_r.unf & ~rd_data_r[5]) | unf_set;
            end else begin
                st2_r.ovf <= st2_r.ovf | ovf_set; // R19
                st2_r.unf <= st2_r.unf | unf_set; // R20
            end
        end
    end
    // water level
    assign wl_rx = cfg_r[CFG_WL_RX_BIT] ? WL_RX_HI : WL_RX_LO; // R15
    assign wl_tx = cfg_r[CFG_WL_TX_BIT] ? WL_TX_HI : WL_TX_LO; // R15
    assign wl_tx_hit = tx_active & ~tx_all_loaded & (
        ((count_r == wl_tx + 7'h01) & (count_nxt == wl_tx)) | // R10
        ((tx_loaded_r < wl_tx) & (count_r == FIFO_LOW_MARK)
            & (count_nxt == FIFO_LOW_MARK - 7'h01))); // R12
    assign wl_rx_hit = rx_active & (count_r == wl_rx - 7'h01) & (count_nxt == wl_rx); // R11
    // a water event during a fifo burst is dropped, not deferred
    assign wl_evt = (wl_tx_hit | wl_rx_hit) & ~fifo_mode; // R13
    // interrupt registers
    always_comb begin
        src_set = main_evt;
        src_set[MAIN_WL_IDX] = wl_evt;
    end
    // main sources; a read clears only what was shown, so new events survive
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            main_src_r <= 6'h00;
        end else if (rd_clr & (addr_r == ADDR_IRQ_MAIN)) begin
            main_src_r <= (main_src_r & ~rd_data_r[7:MAIN_SRC_LSB]) | src_set; // R05
        end else begin
            main_src_r <= main_src_r | src_set; // R03 R08
        end
    end
    assign aux_evt[0] = tim_evt;
    assign aux_evt[1] = err_evt;
    // the two auxiliary registers; their or forms the main pointer bits
    for (genvar g = 0; g < 2; g++) begin : g_aux
        always_ff @(posedge mclk or negedge rst_n) begin
            if (!rst_n) begin
                aux_r[g] <= 8'h00;
            end else if (rd_clr & (addr_r == ADDR_IRQ_TIM + 6'(g))) begin
                aux_r[g] <= (aux_r[g] & ~rd_data_r) | aux_evt[g]; // R05 R06
            end else begin
                aux_r[g] <= aux_r[g] | aux_evt[g]; // R02
            end
        end
    end
    // irq follows unmasked pending bits; low once the last is read
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            irq <= 1'b0;
        end else begin
            irq <= (|(main_src_r & ~mask_r[0][7:MAIN_SRC_LSB]))
                | (|(aux_r[0] & ~mask_r[1]))
                | (|(aux_r[1] & ~mask_r[2])); // R07 R08 R23
        end
    end
    // assertions and covers
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    a_irq_follows: assert property ((|(main_src_r & ~mask_r[0][7:MAIN_SRC_LSB])) |=> irq) // R23
        else $error("irq low with unmasked main source");
    a_irq_drops: assert property ((main_src_r == 6'h00) && (aux_r[0] == 8'h00)
        && (aux_r[1] == 8'h00) |=> !irq) // R07
        else $error("irq high with nothing pending");
    a_masked_keeps: assert property ((main_evt[0] && mask_r[0][MAIN_SRC_LSB]
        && !(MAIN_WL_IDX == 0)) |=> main_src_r[0]) // R08
        else $error("masked source bit not recorded");
    a_aux_clear: assert property ((rd_clr && addr_r == ADDR_IRQ_TIM && tim_evt == 8'h00)
        |=> aux_r[0] == ($past(aux_r[0]) & ~$past(rd_data_r))) // R05
        else $error("timer register not cleared by read");
    a_ptr_holds: assert property ((aux_r[1] != 8'h00) && !(rd_clr && addr_r == ADDR_IRQ_ERR)
        |=> aux_r[1] != 8'h00) // R06
        else $error("error pointer lost before its register read");
    a_ovf_flag: assert property ((push && count_r == FIFO_DEPTH && !rx_start) |=> st2_r.ovf) // R19
        else $error("overflow not flagged");
    a_unf_flag: assert property ((pop && count_r == 7'h00 && !rx_start) |=> st2_r.unf) // R20
        else $error("underflow not flagged");
    a_rx_clear: assert property (rx_start |=> (count_r == 7'h00) && (st2_r == '0)) // R16
        else $error("reception start left fifo state");
    a_fifo_quiet: assert property (fifo_mode |-> !wl_evt) // R13
        else $error("water event during fifo burst");
    a_rx_water: assert property ((rx_active && !fifo_mode && count_r == wl_rx - 7'h01
        && do_push && !do_pop && !flush) |=> main_src_r[MAIN_WL_IDX]) // R11
        else $error("rx water level event missed");
    a_cmd_chain: assert property ((ev && state_r == ST_IDLE && (&byte_r[7:6]) && !ss_m2_r)
        |=> cmd_stb && state_r == ST_IDLE ##1 !cmd_stb) // R01
        else $error("command did not return to mode byte");
    a_count_range: assert property (count_r <= FIFO_DEPTH) // R09
        else $error("fifo count beyond depth");
    c_chain_read: cover property (cmd_stb ##[1:200] (state_r == ST_RD));
    c_overflow: cover property (ovf_set);
    c_water_rx: cover property (wl_rx_hit && !fifo_mode);
    c_irq_cycle: cover property (irq ##[1:500] !irq);

endmodule : hif_top

// >>> sim/hif_host_model.sv
`timescale 1ns/100ps

// serial host; its clock idles low and runs only inside a frame
module hif_host_model (
    output logic sclk,
    output logic ss_n,
    output logic mosi,
    input wire logic miso_o,
    input wire logic miso_oe
);
    initial begin
        sclk = 1'b0;
        ss_n = 1'b1;
        mosi = 1'b0;
    end

    // data moves on rising edges because the device samples on falling ones
    task automatic xfer(input int n, input logic [7:0] tx [40], output logic [7:0] rx [40]);
        ss_n = 1'b0;
        #43;
        for (int i = 0; i < n; i++) begin
            for (int b = 7; b >= 0; b--) begin
                sclk = 1'b1;
                mosi = tx[i][b];
                #40;
                sclk = 1'b0;
                rx[i][b] = miso_oe ? miso_o : ~miso_o; // an undriven line reads inverted
                #40;
            end
        end
        #300;
        ss_n = 1'b1;
        mosi = ~mosi; // released line must not look held
        #100;
    endtask : xfer
endmodule : hif_host_model

// >>> sim/tb_host_irq_and_fifo_status.sv
`timescale 1ns/100ps

module tb_host_irq_and_fifo_status
    import hif_pkg::*;
;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic sclk, ss_n, mosi, miso_o, miso_oe, irq, fr_empty, cmd_stb;
    logic [5:0] main_evt = 6'h00;
    logic [7:0] tim_evt = 8'h00;
    logic [7:0] err_evt = 8'h00;
    logic rx_active = 1'b0;
    logic tx_active = 1'b0;
    logic tx_all_loaded = 1'b0;
    logic rx_start = 1'b0;
    logic fr_push = 1'b0;
    logic fr_pop = 1'b0;
    logic lb_stb = 1'b0;
    logic [7:0] fr_wdata = 8'h00;
    hif_lb_type lb_info = 5'h00;
    logic [7:0] fr_rdata;
    logic [5:0] cmd_code;
    logic [5:0] last_cmd = 6'h00;
    logic [7:0] tx [40];
    logic [7:0] rx [40];
    int errors = 0;
    int comparisons = 0;

    // core clock
    always #4 mclk = ~mclk;

    hif_top uut (.mclk, .rst_n, .sclk, .ss_n, .mosi, .miso_o, .miso_oe, .irq, .main_evt,
        .tim_evt, .err_evt, .rx_active, .tx_active, .tx_all_loaded, .rx_start, .fr_push,
        .fr_wdata, .fr_pop, .fr_rdata, .fr_empty, .lb_stb, .lb_info, .cmd_stb, .cmd_code);
    hif_host_model host (.sclk, .ss_n, .mosi, .miso_o, .miso_oe);

    // the strobe lasts one cycle, so latch what it carried
    always @(posedge mclk) if (cmd_stb === 1'b1) last_cmd <= cmd_code;

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic give_verdict;
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : give_verdict

    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
    endtask : tick

    // register and fifo frames through the host model
    task automatic rreg(input logic [5:0] a, input int n);
        tx[0] = {MODE_READ, a};
        host.xfer(n + 1, tx, rx);
    endtask : rreg

    task automatic wreg(input logic [5:0] a, input logic [7:0] d);
        tx[0] = {MODE_WRITE, a};
        tx[1] = d;
        host.xfer(2, tx, rx);
    endtask : wreg

    task automatic fread(input int n);
        tx[0] = {MODE_FIFO, FIFO_READ_CODE};
        host.xfer(n + 1, tx, rx);
    endtask : fread

    // event pulses, one cycle wide
    task automatic ev(input logic [5:0] m, input logic [7:0] t, input logic [7:0] e);
        @(posedge mclk);
        main_evt <= m;
        tim_evt <= t;
        err_evt <= e;
        @(posedge mclk);
        main_evt <= 6'h00;
        tim_evt <= 8'h00;
        err_evt <= 8'h00;
        tick(3);
    endtask : ev

    // back-to-back receiver writes
    task automatic push(input int n, input logic [7:0] base);
        for (int i = 0; i < n; i++) begin
            @(posedge mclk);
            fr_push <= 1'b1;
            fr_wdata <= base + 8'(i);
        end
        @(posedge mclk);
        fr_push <= 1'b0;
        tick(3);
    endtask : push

    task automatic pop;
        @(posedge mclk);
        fr_pop <= 1'b1;
        @(posedge mclk);
        fr_pop <= 1'b0;
        tick(3);
    endtask : pop

    task automatic rx_begin;
        @(posedge mclk);
        rx_active <= 1'b1;
        rx_start <= 1'b1;
        @(posedge mclk);
        rx_start <= 1'b0;
        tick(2);
    endtask : rx_begin

    // raise, mask, and the pointers into the auxiliary registers
    task automatic t_irq;
        ev(6'h01, 8'h00, 8'h00);
        check("irq set", 8'(irq), 8'h01);
        rreg(ADDR_IRQ_MAIN, 3);
        check("main", rx[1], 8'h04);
        check("irq clear", 8'(irq), 8'h00);
        wreg(ADDR_MASK_MAIN, 8'h04);
        ev(6'h01, 8'h01, 8'h80);
        check("irq aux", 8'(irq), 8'h01);
        rreg(ADDR_IRQ_MAIN, 1);
        check("main masked", rx[1], 8'h07);
        rreg(ADDR_IRQ_MAIN, 1);
        check("main ptr", rx[1], 8'h03);
        check("irq held", 8'(irq), 8'h01);
        rreg(ADDR_IRQ_TIM, 2);
        check("timer", rx[1], 8'h01);
        check("error", rx[2], 8'h80);
        rreg(ADDR_IRQ_MAIN, 1);
        check("main empty", rx[1], 8'h00);
        check("irq off", 8'(irq), 8'h00);
        ev(6'h01, 8'h00, 8'h00);
        check("irq masked", 8'(irq), 8'h00);
        rreg(ADDR_IRQ_MAIN, 1);
        wreg(ADDR_MASK_MAIN, 8'h00);
    endtask : t_irq

    // reception with the high level chosen, then overflow and underflow
    task automatic t_rx;
        wreg(ADDR_IO_CFG1, 8'h01);
        rx_begin;
        push(64, 8'h00);
        check("irq low level", 8'(irq), 8'h00);
        push(16, 8'h40);
        check("irq rx level", 8'(irq), 8'h01);
        rreg(ADDR_IRQ_MAIN, 1);
        check("main water", rx[1], 8'h40);
        push(17, 8'h50);
        @(posedge mclk);
        lb_stb <= 1'b1;
        lb_info <= 5'h1b;
        @(posedge mclk);
        lb_stb <= 1'b0;
        rreg(ADDR_FIFO_ST1, 3);
        check("count full", rx[1], 8'h60);
        check("status2", rx[2], 8'h5b);
        check("unmapped", rx[3], 8'h00);
        rreg(ADDR_FIFO_ST2, 1);
        check("status2 read", rx[1], 8'h00);
        fread(3);
        for (int i = 1; i < 4; i++) check("fifo data", rx[i], 8'(i - 1));
        rreg(ADDR_FIFO_ST1, 1);
        check("count live", rx[1], 8'h5d);
        rx_begin;
        check("flushed", 8'(fr_empty), 8'h01);
        fread(1);
        rreg(ADDR_FIFO_ST1, 2);
        check("count zero", rx[1], 8'h00);
        check("underflow", rx[2], 8'h20);
        @(posedge mclk);
        rx_active <= 1'b0;
    endtask : t_rx

    // chained clear and load, the water level and the short-load mark
    task automatic t_tx;
        @(posedge mclk);
        tx_active <= 1'b1;
        tx[0] = {2'h3, CMD_CLEAR_A};
        tx[1] = {MODE_FIFO, FIFO_LOAD_CODE};
        for (int i = 2; i < 35; i++) tx[i] = 8'(i + 8'h80);
        host.xfer(35, tx, rx);
        check("command", 8'(last_cmd), 8'(CMD_CLEAR_A));
        check("head", fr_rdata, 8'h82);
        rreg(ADDR_FIFO_ST1, 1);
        check("tx count", rx[1], 8'h21);
        pop;
        check("irq tx level", 8'(irq), 8'h01);
        rreg(ADDR_IRQ_MAIN, 1);
        check("main tx water", rx[1], 8'h40);
        tx[0] = {2'h3, CMD_CLEAR_B};
        host.xfer(7, tx, rx);
        @(posedge mclk);
        tx_all_loaded <= 1'b1;
        pop;
        check("irq at four", 8'(irq), 8'h00);
        pop;
        check("irq all loaded", 8'(irq), 8'h00);
        // one more byte brings the count back to four for the short-load mark
        tx[0] = {MODE_FIFO, FIFO_LOAD_CODE};
        host.xfer(2, tx, rx);
        @(posedge mclk);
        tx_all_loaded <= 1'b0;
        pop;
        check("irq below four", 8'(irq), 8'h01);
        @(posedge mclk);
        tx_active <= 1'b0;
    endtask : t_tx

    // reset, then the scenarios in turn
    initial begin
        tick(3);
        check("irq in reset", 8'(irq), 8'h00);
        check("empty in reset", 8'(fr_empty), 8'h01);
        check("oe in reset", 8'(miso_oe), 8'h00);
        tick(2);
        rst_n <= 1'b1;
        tick(4);
        t_irq;
        t_rx;
        t_tx;
        give_verdict;
    end

    // watchdog, far beyond the expected run length
    initial begin
        #500000;
        errors++;
        give_verdict;
    end
endmodule : tb_host_irq_and_fifo_status
